// file: hdl/dma_request_source_select.sv
// request source selection front end for a four channel dma controller
// assumes peripheral events are one-cycle pulses on clk_sys, pins are async
`timescale 1ns/1ns
`include "dma_req_defs.svh"

// Overview of operation
// - four channels, each with own source select
// - timers, uart0/uart2 transmit, converter on bank zero
// - code zero pin falling edge, one software
// - bank one code five: serial3, odd channels
// - bank one code six: both edges or serial4
// - even channels timers b3-b5; odd both edges at code seven
// - uart0 receive, odd channels also acknowledge
// - uart2 receive, odd channels also acknowledge
// - uart1 transmit even, receive/acknowledge odd
module dma_request_source_select (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// per channel selection
	input dma_req_pkg::code_t request_source_code [`CHANNEL_COUNT],
	input wire dma_req_pkg::chan_vec_t source_bank_extend,
	input wire dma_req_pkg::chan_vec_t software_trigger,
	// external interrupt pins, one per channel, asynchronous
	input wire dma_req_pkg::chan_vec_t external_interrupt_pin,
	// timer events
	input wire logic [4:0] timer_a_event,
	input wire logic [5:0] timer_b_event,
	// serial events
	input wire logic uart0_tx_event,
	input wire logic uart0_rx_event,
	input wire logic uart0_acknowledge_event,
	input wire logic uart1_tx_event,
	input wire logic uart1_rx_event,
	input wire logic uart1_acknowledge_event,
	input wire logic uart2_tx_event,
	input wire logic uart2_rx_event,
	input wire logic uart2_acknowledge_event,
	input wire logic clocked_serial_port_3,
	input wire logic clocked_serial_port_4,
	// converter event
	input wire logic ad_done_event,
	// transfer requests to the engine
	output dma_req_pkg::chan_vec_t dma_request
);
	import dma_req_pkg::*;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// the bank bit is part of every match, so the two banks never alias
	function automatic logic code_match(
		input logic bank,
		input code_t code,
		input logic want_bank,
		input code_t want_code
	);
		return (bank == want_bank) && (code == want_code);
	endfunction : code_match

	// timers a0..a4 then b0..b2 sit on consecutive bank zero codes
	function automatic logic timer_slot(
		input logic bank,
		input code_t code
	);
		return !bank && (code >= `SRC_TA0) && (code <= `SRC_TB2);
	endfunction : timer_slot

	// ----------------------------------------
	// event gathering
	// ----------------------------------------
	wire event_vec_t periph_events;
	assign periph_events = {
		clocked_serial_port_4,
		clocked_serial_port_3,
		ad_done_event,
		uart2_acknowledge_event,
		uart2_rx_event,
		uart2_tx_event,
		uart1_acknowledge_event,
		uart1_rx_event,
		uart1_tx_event,
		uart0_acknowledge_event,
		uart0_rx_event,
		uart0_tx_event,
		timer_b_event,
		timer_a_event
	};

	// ----------------------------------------
	// per channel pin edges and selection
	// ----------------------------------------
	wire chan_vec_t pin_fall;
	wire chan_vec_t pin_both;
	wire chan_vec_t request_d;
	wire logic [7:0] bank0_timers;
	chan_vec_t request_q;

	// timers in code order, indexed by code minus the first timer code
	assign bank0_timers = periph_events[`EV_TA0 +: 8];

	for (genvar ch = 0; ch < `CHANNEL_COUNT; ch++) begin : g_chan
		// odd channels (1, 3) carry the alternate source set
		localparam bit odd_c = (ch % 2) == 1;
		wire code_t code_c;
		wire logic bank_c;
		wire logic [2:0] timer_idx;
		wire logic slot_fall;
		wire logic slot_soft;
		wire logic slot_timer;
		wire logic slot_u0_tx;
		wire logic slot_u0_rx;
		wire logic slot_u2_tx;
		wire logic slot_u2_rx;
		wire logic slot_ad;
		wire logic slot_u1;
		wire logic slot_serial3;
		wire logic slot_edge_or_s4;
		wire logic slot_tb3_or_edge;
		wire logic slot_tb4;
		wire logic slot_tb5;
		wire logic hit_fall;
		wire logic hit_soft;
		wire logic hit_timer;
		wire logic hit_u0_tx;
		wire logic hit_u0_rx;
		wire logic hit_u2_tx;
		wire logic hit_u2_rx;
		wire logic hit_ad;
		wire logic hit_u1;
		wire logic hit_serial3;
		wire logic hit_edge_or_s4;
		wire logic hit_tb3_or_edge;
		wire logic hit_tb4;
		wire logic hit_tb5;

		pin_edge_detect u_edge (
			.clk_sys(clk_sys),
			.rst(rst),
			.pin(external_interrupt_pin[ch]),
			.fall_pulse(pin_fall[ch]),
			.any_edge_pulse(pin_both[ch])
		);

		// ----------------------------------------
		// channel operands
		// ----------------------------------------
		assign code_c = request_source_code[ch];
		assign bank_c = source_bank_extend[ch];
		// meaningless outside the timer slots, masked there by slot_timer
		assign timer_idx = 3'(code_c - `SRC_TA0);

		// ----------------------------------------
		// slot decode, bank extension clear
		// ----------------------------------------
		assign slot_fall = code_match(bank_c, code_c, 1'b0, `SRC_FALLING);
		assign slot_soft = code_match(bank_c, code_c, 1'b0, `SRC_SOFTWARE);
		assign slot_timer = timer_slot(bank_c, code_c);
		assign slot_u0_tx = code_match(bank_c, code_c, 1'b0, `SRC_U0_TX);
		assign slot_u0_rx = code_match(bank_c, code_c, 1'b0, `SRC_U0_RX);
		assign slot_u2_tx = code_match(bank_c, code_c, 1'b0, `SRC_U2_TX);
		assign slot_u2_rx = code_match(bank_c, code_c, 1'b0, `SRC_U2_RX);
		assign slot_ad = code_match(bank_c, code_c, 1'b0, `SRC_AD);
		assign slot_u1 = code_match(bank_c, code_c, 1'b0, `SRC_U1);

		// ----------------------------------------
		// slot decode, bank extension set
		// ----------------------------------------
		assign slot_serial3 = code_match(bank_c, code_c, 1'b1, `SRCX_SERIAL3);
		assign slot_edge_or_s4 = code_match(bank_c, code_c, 1'b1, `SRCX_BOTH_OR_SERIAL4);
		assign slot_tb3_or_edge = code_match(bank_c, code_c, 1'b1, `SRCX_TB3_OR_BOTH);
		assign slot_tb4 = code_match(bank_c, code_c, 1'b1, `SRCX_TB4);
		assign slot_tb5 = code_match(bank_c, code_c, 1'b1, `SRCX_TB5);

		// ----------------------------------------
		// event gating per slot
		// ----------------------------------------
		assign hit_fall = slot_fall & pin_fall[ch];
		assign hit_soft = slot_soft & software_trigger[ch];
		assign hit_timer = slot_timer & bank0_timers[timer_idx];
		assign hit_u0_tx = slot_u0_tx & periph_events[`EV_U0_TX];
		assign hit_u2_tx = slot_u2_tx & periph_events[`EV_U2_TX];
		assign hit_ad = slot_ad & periph_events[`EV_AD];
		assign hit_u0_rx = slot_u0_rx
			& (periph_events[`EV_U0_RX] | (odd_c & periph_events[`EV_U0_ACK]));
		assign hit_u2_rx = slot_u2_rx
			& (periph_events[`EV_U2_RX] | (odd_c & periph_events[`EV_U2_ACK]));
		assign hit_u1 = slot_u1
			& (odd_c ? (periph_events[`EV_U1_RX] | periph_events[`EV_U1_ACK]) : periph_events[`EV_U1_TX]);
		assign hit_serial3 = slot_serial3 & odd_c & periph_events[`EV_SERIAL3];
		assign hit_edge_or_s4 = slot_edge_or_s4 & (odd_c ? periph_events[`EV_SERIAL4] : pin_both[ch]);
		assign hit_tb3_or_edge = slot_tb3_or_edge & (odd_c ? pin_both[ch] : periph_events[`EV_TB3]);
		assign hit_tb4 = slot_tb4 & ~odd_c & periph_events[`EV_TB4];
		assign hit_tb5 = slot_tb5 & ~odd_c & periph_events[`EV_TB5];

		// a combination with no source matches no slot or is masked by odd_c, so every term stays low
		assign request_d[ch] = hit_fall
			| hit_soft
			| hit_timer
			| hit_u0_tx
			| hit_u2_tx
			| hit_ad
			| hit_u0_rx
			| hit_u2_rx
			| hit_u1
			| hit_serial3
			| hit_edge_or_s4
			| hit_tb3_or_edge
			| hit_tb4
			| hit_tb5;
	end

	// ----------------------------------------
	// registered request output
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			request_q <= `REQUEST_RESET;
		end else begin
			request_q <= request_d;
		end
	end

	assign dma_request = request_q;
endmodule : dma_request_source_select

// file: hdl/dma_req_defs.svh
// constants for the dma request source selection block
// included by the package and the design modules; definitions only
`ifndef DMA_REQ_DEFS_SVH
`define DMA_REQ_DEFS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define CHANNEL_COUNT 4
`define CODE_WIDTH 5
`define EVENT_COUNT 23

// ----------------------------------------
// source codes, bank extension clear
// ----------------------------------------
`define SRC_FALLING 5'h00
`define SRC_SOFTWARE 5'h01
`define SRC_TA0 5'h02
`define SRC_TB2 5'h09
`define SRC_U0_TX 5'h0a
`define SRC_U0_RX 5'h0b
`define SRC_U2_TX 5'h0c
`define SRC_U2_RX 5'h0d
`define SRC_AD 5'h0e
`define SRC_U1 5'h0f

// ----------------------------------------
// source codes, bank extension set
// ----------------------------------------
`define SRCX_SERIAL3 5'h05
`define SRCX_BOTH_OR_SERIAL4 5'h06
`define SRCX_TB3_OR_BOTH 5'h07
`define SRCX_TB4 5'h08
`define SRCX_TB5 5'h09

// ----------------------------------------
// peripheral event vector bit positions
// ----------------------------------------
`define EV_TA0 0
`define EV_TB3 8
`define EV_TB4 9
`define EV_TB5 10
`define EV_U0_TX 11
`define EV_U0_RX 12
`define EV_U0_ACK 13
`define EV_U1_TX 14
`define EV_U1_RX 15
`define EV_U1_ACK 16
`define EV_U2_TX 17
`define EV_U2_RX 18
`define EV_U2_ACK 19
`define EV_AD 20
`define EV_SERIAL3 21
`define EV_SERIAL4 22

// ----------------------------------------
// reset values
// ----------------------------------------
`define PIN_IDLE_LEVEL 1'b1
`define REQUEST_RESET 4'h0

`endif

// file: hdl/dma_req_pkg.sv
// types shared by the dma request source selection block
// assumes dma_req_defs.svh is on the include path
`include "dma_req_defs.svh"

package dma_req_pkg;
	typedef logic [`CODE_WIDTH-1:0] code_t;
	typedef logic [`CHANNEL_COUNT-1:0] chan_vec_t;
	typedef logic [`EVENT_COUNT-1:0] event_vec_t;
endpackage : dma_req_pkg

// file: hdl/pin_edge_detect.sv
// synchroniser and edge detector for one external interrupt pin
// assumes the pin is asynchronous to clk_sys and idles high
`timescale 1ns/1ns
`include "dma_req_defs.svh"

module pin_edge_detect (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// pin
	input wire logic pin,
	// detected edges, one-cycle pulses
	output logic fall_pulse,
	output logic any_edge_pulse
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q <= `PIN_IDLE_LEVEL;
			sync_q <= `PIN_IDLE_LEVEL;
			prev_q <= `PIN_IDLE_LEVEL;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// only the second stage and its history feed the edge logic
	assign fall_pulse = prev_q & ~sync_q;
	assign any_edge_pulse = prev_q ^ sync_q;
endmodule : pin_edge_detect

// file: tb/dma_request_source_select_props.sv
// checker for the request selection outputs
// assumes it is bound into dma_request_source_select
`timescale 1ns/1ns
`include "dma_req_defs.svh"
module dma_request_source_select_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// selection and events
	input dma_req_pkg::code_t request_source_code [`CHANNEL_COUNT],
	input wire dma_req_pkg::chan_vec_t source_bank_extend,
	input wire dma_req_pkg::chan_vec_t software_trigger,
	input wire logic [4:0] timer_a_event,
	input wire logic uart0_tx_event,
	input wire logic ad_done_event,
	// requests
	input wire dma_req_pkg::chan_vec_t dma_request
);
	import dma_req_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire code_t c0 = request_source_code[0];
	wire code_t c1 = request_source_code[1];
	wire code_t c2 = request_source_code[2];
	wire code_t c3 = request_source_code[3];
	wire chan_vec_t x = source_bank_extend;
	chk_reset_quiet: assert property (disable iff (1'b0) rst |=> dma_request == 4'h0)
		else $error("request out of reset");
	chk_soft_trigger: assert property (!x[0] && c0 == 5'h01 && software_trigger[0] |=> dma_request[0])
		else $error("software trigger lost");
	chk_timer_a0: assert property (!x[2] && c2 == 5'h02 && timer_a_event[0] |=> dma_request[2])
		else $error("timer event lost");
	chk_uart_tx: assert property (!x[3] && c3 == 5'h0a && uart0_tx_event |=> dma_request[3])
		else $error("uart0 transmit lost");
	chk_converter_done: assert property (!x[1] && c1 == 5'h0e && ad_done_event |=> dma_request[1])
		else $error("converter event lost");
	chk_serial_even: assert property (x[0] && c0 == 5'h05 |=> !dma_request[0])
		else $error("even channel took serial port");
	chk_upper_codes: assert property (c3[4] |=> !dma_request[3])
		else $error("request from unassigned code");
	chk_low_bank: assert property (x[2] && c2 < 5'h05 |=> !dma_request[2])
		else $error("request from empty bank slot");
	cover property (dma_request[0]);
	cover property (dma_request[1] ##1 !dma_request[1]);
	cover property (dma_request == 4'h0 ##1 dma_request[3]);
endmodule : dma_request_source_select_chk
bind dma_request_source_select dma_request_source_select_chk dma_request_source_select_chk_i (.*);

// file: tb/periph_model.sv
// peripheral side: one event pulse per fire cycle
// assumes fire lasts one cycle, idx names an event bit
`timescale 1ns/1ns
module periph_model (
	input wire logic clk_sys,
	input wire logic fire,
	input wire logic [4:0] idx,
	output dma_req_pkg::event_vec_t ev
);
	import dma_req_pkg::*;
	always_ff @(posedge clk_sys) begin
		ev <= fire ? event_vec_t'(1) << idx : '0;
	end
endmodule : periph_model

// file: tb/tb.sv
// bench for the request source selection block
// assumes periph_model drives one-hot event pulses
`timescale 1ns/1ns
module tb;
	import dma_req_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	code_t code_sel [4] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f};
	chan_vec_t ext_sel = 4'hf;
	chan_vec_t sw = 4'h0;
	chan_vec_t pin = 4'hf;
	logic fire = 1'b0;
	logic [4:0] idx = 5'h00;
	event_vec_t ev;
	chan_vec_t dma_request;
	int mismatches = 0;
	int n_tests = 0;
	always #10 clk_sys = ~clk_sys;
	periph_model periph_model_i (.clk_sys(clk_sys), .fire(fire), .idx(idx), .ev(ev));
	dma_request_source_select dma_request_source_select_i (.clk_sys(clk_sys), .rst(rst),
		.request_source_code(code_sel), .source_bank_extend(ext_sel), .software_trigger(sw),
		.external_interrupt_pin(pin), .timer_a_event(ev[4:0]), .timer_b_event(ev[10:5]),
		.uart0_tx_event(ev[11]), .uart0_rx_event(ev[12]), .uart0_acknowledge_event(ev[13]),
		.uart1_tx_event(ev[14]), .uart1_rx_event(ev[15]), .uart1_acknowledge_event(ev[16]),
		.uart2_tx_event(ev[17]), .uart2_rx_event(ev[18]), .uart2_acknowledge_event(ev[19]),
		.ad_done_event(ev[20]), .clocked_serial_port_3(ev[21]), .clocked_serial_port_4(ev[22]),
		.dma_request(dma_request));
	task automatic step(int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : step
	task automatic check(logic [3:0] seen, logic [3:0] want);
		n_tests++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic conclude();
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	// one event through the partner; idle channels sit on an unassigned code
	task automatic try_ev(int ch, logic x, code_t c, int k, logic hit);
		code_sel[ch] = c;
		ext_sel[ch] = x;
		idx = 5'(k);
		fire = 1;
		step(1);
		fire = 0;
		step(1);
		check(dma_request, 4'(hit) << ch);
		code_sel[ch] = 5'h1f;
		ext_sel[ch] = 1;
		step(1);
		check(dma_request, 4'h0);
	endtask : try_ev
	task automatic s_bank0();
		for (int k = 0; k < 8; k++) begin
			try_ev(2, 0, 5'(k + 2), k, 1);
		end
		try_ev(3, 0, 5'h0a, 11, 1);
		try_ev(3, 0, 5'h0c, 17, 1);
		try_ev(1, 0, 5'h0e, 20, 1);
	endtask : s_bank0
	task automatic s_uart();
		try_ev(0, 0, 5'h0b, 13, 0);
		try_ev(1, 0, 5'h0b, 13, 1);
		try_ev(2, 0, 5'h0b, 12, 1);
		try_ev(3, 0, 5'h0d, 19, 1);
		try_ev(2, 0, 5'h0d, 19, 0);
		try_ev(2, 0, 5'h0d, 18, 1);
		try_ev(0, 0, 5'h0f, 14, 1);
		try_ev(1, 0, 5'h0f, 14, 0);
		try_ev(3, 0, 5'h0f, 16, 1);
		try_ev(1, 0, 5'h0f, 15, 1);
	endtask : s_uart
	task automatic s_bank1();
		try_ev(1, 1, 5'h05, 21, 1);
		try_ev(0, 1, 5'h05, 21, 0);
		try_ev(3, 1, 5'h06, 22, 1);
		try_ev(2, 1, 5'h07, 8, 1);
		try_ev(2, 1, 5'h08, 9, 1);
		try_ev(3, 1, 5'h08, 9, 0);
		try_ev(0, 1, 5'h09, 10, 1);
		try_ev(2, 1, 5'h03, 3, 0);
		try_ev(0, 1, 5'h0a, 11, 0);
		try_ev(1, 0, 5'h12, 0, 0);
	endtask : s_bank1
	task automatic s_soft();
		code_sel[0] = 5'h01;
		ext_sel[0] = 0;
		sw = 4'h3;
		step(1);
		sw = 4'h0;
		check(dma_request, 4'h1);
		code_sel[0] = 5'h1f;
		ext_sel[0] = 1;
		step(1);
		check(dma_request, 4'h0);
	endtask : s_soft
	// ch0 falling only, ch1 and ch2 both edges; pins pass two sync flops
	task automatic s_pin();
		code_sel[0] = 5'h00;
		ext_sel[0] = 0;
		code_sel[1] = 5'h07;
		code_sel[2] = 5'h06;
		pin = 4'h0;
		step(3);
		check(dma_request, 4'h7);
		pin = 4'hf;
		step(3);
		check(dma_request, 4'h6);
		step(1);
		check(dma_request, 4'h0);
	endtask : s_pin
	initial begin
		step(20);
		rst = 0;
		step(3);
		s_bank0();
		s_uart();
		s_bank1();
		s_soft();
		s_pin();
		conclude();
	end
endmodule : tb
